// >>> src/mra_pkg.sv
package mra_pkg;

  localparam int MRA_NUM_REGIONS = 8;
  localparam int MRA_ADDR_W = 8;

  // Byte offsets from the block's base address
  localparam logic [7:0] MRA_OFF_TYPE = 8'h00;
  localparam logic [7:0] MRA_OFF_NUMBER = 8'h08;
  localparam logic [7:0] MRA_OFF_BASE = 8'h0c;
  localparam logic [7:0] MRA_OFF_ATTR = 8'h10;
  localparam logic [7:0] MRA_OFF_BASE_A1 = 8'h14;
  localparam logic [7:0] MRA_OFF_ATTR_A1 = 8'h18;
  localparam logic [7:0] MRA_OFF_BASE_A2 = 8'h1c;
  localparam logic [7:0] MRA_OFF_ATTR_A2 = 8'h20;
  localparam logic [7:0] MRA_OFF_BASE_A3 = 8'h24;
  localparam logic [7:0] MRA_OFF_ATTR_A3 = 8'h28;

  // Attribute register field positions
  localparam int MRA_POS_XN = 28;
  localparam int MRA_POS_AP = 24;
  localparam int MRA_POS_TEX = 19;
  localparam int MRA_POS_S = 18;
  localparam int MRA_POS_C = 17;
  localparam int MRA_POS_B = 16;
  localparam int MRA_POS_SRD = 8;
  localparam int MRA_POS_SIZE = 1;
  localparam int MRA_POS_EN = 0;

  // Base and type register field positions
  localparam int MRA_POS_VALID = 4;
  localparam int MRA_POS_ADDR = 5;
  localparam int MRA_POS_TYPE_DREGION = 8;

  // Subregions exist only from 256 bytes upward (N of 8)
  localparam logic [5:0] MRA_SUBREGION_MIN_N = 6'h08;
  localparam logic [5:0] MRA_SUBREGION_SHIFT = 6'h03;

  localparam logic [1:0] MRA_RESP_OKAY = 2'h0;
  localparam logic [1:0] MRA_RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    MRA_KIND_NONE = 5'h01,
    MRA_KIND_TYPE = 5'h02,
    MRA_KIND_NUMBER = 5'h04,
    MRA_KIND_BASE = 5'h08,
    MRA_KIND_ATTR = 5'h10
  } mra_kind_t;

  typedef struct packed {
    logic xn;
    logic [2:0] ap;
    logic [2:0] type_ext_field;
    logic s;
    logic c;
    logic b;
    logic [7:0] subregion_off_mask;
    logic [4:0] size;
    logic en;
    logic [26:0] base;
  } mra_region_t;

  typedef struct packed {
    logic [MRA_NUM_REGIONS-1:0] hit;
    logic fetchBlocked;
  } mra_check_t;

endpackage : mra_pkg

// >>> src/mra_regs.sv
// What this block does
// RULE1: Word and halfword writes to attribute registers and aliases are honoured.
// RULE2: Upper halfword holds attributes; lower holds size, subregion mask, enable.
// RULE3: Attribute accesses act on selected region; each region stores its own.
// RULE4: Execute-never bit 28 set blocks instruction fetches from the region.
// RULE5: Type extension bits 21:19, shareable 18, cacheable 17, bufferable 16.
// RULE6: Subregion mask bits 15:8; a set bit excludes its subregion.
// RULE7: Software writes a zero subregion mask for regions of 128 bytes or less.
// RULE8: Region size in bytes is two to the power size plus one.
// RULE9: Software programs size at least 4, a 32-byte region.
// RULE10: Size 31 covers all 4 GB from base zero; base field ignored.
// RULE11: Enable bit 0 switches the region; subregions then follow the mask.
// RULE12: Base field is bits 31 down to N; lower bits do not match.
// RULE13: Software aligns the base address to the region size.
// RULE14: Base write with valid 0 updates the selected region, number kept.
// RULE15: Base write with valid 1 loads region number, then updates that base.
// RULE16: Base register reads return valid bit as zero.
// RULE17: Base register reads return current region number in low bits.
// RULE18: Eight regions; region numbers 0 to 7 only.
// RULE19: Alias registers reach the same storage and behave identically.
`timescale 1ns/1ps
module mra_regs (
  input wire logic mclk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic [mra_pkg::MRA_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [mra_pkg::MRA_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [31:0] chkAddr, // Address being judged
  input wire logic chkFetch, // Access is an instruction fetch
  output mra_pkg::mra_check_t chkResult // Judgement, one cycle later
);
  import mra_pkg::*;

  localparam int RW = $clog2(MRA_NUM_REGIONS);

  mra_region_t regions [MRA_NUM_REGIONS];
  logic [RW-1:0] regionSel;
  logic [MRA_ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic awHeld;
  logic wHeld;

  function automatic mra_kind_t decodeKind(input logic [MRA_ADDR_W-1:0] a);
    logic [7:0] w;
    w = {a[MRA_ADDR_W-1:2], 2'b00};
    if (w == MRA_OFF_TYPE)
      return MRA_KIND_TYPE;
    if (w == MRA_OFF_NUMBER)
      return MRA_KIND_NUMBER;
    if (w == MRA_OFF_BASE || w == MRA_OFF_BASE_A1 || // RULE19
        w == MRA_OFF_BASE_A2 || w == MRA_OFF_BASE_A3)
      return MRA_KIND_BASE;
    if (w == MRA_OFF_ATTR || w == MRA_OFF_ATTR_A1 ||
        w == MRA_OFF_ATTR_A2 || w == MRA_OFF_ATTR_A3)
      return MRA_KIND_ATTR;
    return MRA_KIND_NONE;
  endfunction : decodeKind

  // Log2 of the region size in bytes
  function automatic logic [5:0] sizeToN(input logic [4:0] size);
    return {1'b0, size} + 6'h01; // RULE8
  endfunction : sizeToN

  // Mask of the bits below N; size 31 gives all ones, so base is ignored
  function automatic logic [31:0] lowMask(input logic [4:0] size);
    logic [5:0] n;
    n = sizeToN(size);
    return (32'h1 << n) - 32'h1; // RULE10
  endfunction : lowMask

  function automatic logic [31:0] packAttr(input mra_region_t r);
    logic [31:0] v;
    v = '0;
    v[MRA_POS_XN] = r.xn;
    v[MRA_POS_AP +: 3] = r.ap;
    v[MRA_POS_TEX +: 3] = r.type_ext_field; // RULE5
    v[MRA_POS_S] = r.s;
    v[MRA_POS_C] = r.c;
    v[MRA_POS_B] = r.b;
    v[MRA_POS_SRD +: 8] = r.subregion_off_mask; // RULE2
    v[MRA_POS_SIZE +: 5] = r.size;
    v[MRA_POS_EN] = r.en;
    return v;
  endfunction : packAttr

  function automatic logic [31:0] packBase(input mra_region_t r);
    logic [31:0] v;
    v = {r.base, 5'h00} & ~lowMask(r.size); // RULE12
    return v;
  endfunction : packBase

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        v[8*i +: 8] = nw[8*i +: 8]; // RULE1
    return v;
  endfunction : mergeBytes

  // Write side
  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire mra_kind_t wrKind = decodeKind(awAddr);
  wire wrValid = wStrb[0] && wData[MRA_POS_VALID];
  wire [RW-1:0] wrRegion = wrValid ? wData[RW-1:0] : regionSel; // RULE14
  wire [31:0] attrNew = mergeBytes(packAttr(regions[regionSel]),
                                   wData, wStrb); // RULE3
  wire [31:0] baseNew = mergeBytes(packBase(regions[wrRegion]),
                                   wData, wStrb);
  wire wrMapped = (wrKind != MRA_KIND_NONE);

  // One strobe per target, so the update blocks stay plain
  wire wrAttr = doWrite && (wrKind == MRA_KIND_ATTR);
  wire wrBase = doWrite && (wrKind == MRA_KIND_BASE);
  wire wrNumber = doWrite && (wrKind == MRA_KIND_NUMBER) && wStrb[0];
  wire wrSelect = wrBase && wrValid;
  // The type word is read-only; a write to it is dropped and flagged with SLVERR
  wire [1:0] wrResp = (wrMapped && wrKind != MRA_KIND_TYPE) ?
                      MRA_RESP_OKAY : MRA_RESP_SLVERR;

  // Fields of the merged attribute word
  wire attrXn = attrNew[MRA_POS_XN];
  wire [2:0] attrAp = attrNew[MRA_POS_AP +: 3];
  wire [2:0] attrTex = attrNew[MRA_POS_TEX +: 3];
  wire attrS = attrNew[MRA_POS_S];
  wire attrC = attrNew[MRA_POS_C];
  wire attrB = attrNew[MRA_POS_B];
  wire [7:0] attrSrd = attrNew[MRA_POS_SRD +: 8];
  wire [4:0] attrSize = attrNew[MRA_POS_SIZE +: 5];
  wire attrEn = attrNew[MRA_POS_EN];

  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;

  // Address and data arrive in either order; each waits for the other
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end
    else if (doWrite)
      awHeld <= 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wHeld <= 1'b0;
      wData <= '0;
      wStrb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end
    else if (doWrite)
      wHeld <= 1'b0;
  end

  // Response stands until taken; no new write performs meanwhile
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s_axi_bvalid <= 1'b0;
    else if (doWrite)
      s_axi_bvalid <= 1'b1;
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s_axi_bresp <= MRA_RESP_OKAY;
    else if (doWrite)
      s_axi_bresp <= wrResp;
  end

  // Region number: only the low bits exist, so 0 to 7 are reachable
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      regionSel <= '0;
    else if (wrNumber)
      regionSel <= wData[RW-1:0]; // RULE18
    else if (wrSelect)
      regionSel <= wData[RW-1:0]; // RULE15
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < MRA_NUM_REGIONS; i++)
        regions[i] <= '0;
    end
    else if (wrAttr)
    begin
      regions[regionSel].xn <= attrXn; // RULE4
      regions[regionSel].ap <= attrAp;
      regions[regionSel].type_ext_field <= attrTex; // RULE5
      regions[regionSel].s <= attrS;
      regions[regionSel].c <= attrC;
      regions[regionSel].b <= attrB;
      regions[regionSel].subregion_off_mask <= attrSrd; // RULE6
      regions[regionSel].size <= attrSize;
      regions[regionSel].en <= attrEn; // RULE11
    end
    else if (wrBase)
      regions[wrRegion].base <= baseNew[31:MRA_POS_ADDR]; // RULE15
  end

  // Read side
  wire mra_kind_t rdKind = decodeKind(s_axi_araddr);
  wire [1:0] rdResp = (rdKind == MRA_KIND_NONE) ? MRA_RESP_SLVERR :
                      MRA_RESP_OKAY;
  wire [31:0] typeWord = 32'(MRA_NUM_REGIONS) << MRA_POS_TYPE_DREGION;
  wire [31:0] baseRead = packBase(regions[regionSel]) |
                         {29'h0, regionSel}; // RULE16 RULE17
  logic [31:0] rdWord;

  // Unmapped offsets read as zero, flagged by the response
  always_comb
  begin
    rdWord = 32'h0;
    unique case (rdKind)
      MRA_KIND_TYPE:
        rdWord = typeWord;
      MRA_KIND_NUMBER:
        rdWord = {29'h0, regionSel};
      MRA_KIND_BASE:
        rdWord = baseRead;
      MRA_KIND_ATTR:
        rdWord = packAttr(regions[regionSel]); // RULE3
      MRA_KIND_NONE:
        rdWord = 32'h0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Data is captured once per request and stands until taken
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s_axi_rvalid <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      s_axi_rvalid <= 1'b1;
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rdata <= '0;
      s_axi_rresp <= MRA_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdResp;
    end
  end

  // Protection check: which enabled regions cover the address
  logic [MRA_NUM_REGIONS-1:0] hitNow;
  logic [MRA_NUM_REGIONS-1:0] xnNow;

  always_comb
  begin
    logic [31:0] m;
    logic [5:0] n;
    logic [2:0] sub;
    m = '0;
    n = '0;
    sub = '0;
    hitNow = '0;
    xnNow = '0;
    for (int i = 0; i < MRA_NUM_REGIONS; i++)
    begin
      m = lowMask(regions[i].size);
      n = sizeToN(regions[i].size);
      sub = 3'(chkAddr >> (n - MRA_SUBREGION_SHIFT));
      hitNow[i] = regions[i].en && // RULE11
                  ((chkAddr & ~m) == ({regions[i].base, 5'h00} & ~m)); // RULE12
      // Small regions have no subregions, so the mask is not consulted
      if (n >= MRA_SUBREGION_MIN_N && regions[i].subregion_off_mask[sub])
        hitNow[i] = 1'b0; // RULE6
      xnNow[i] = hitNow[i] && regions[i].xn;
    end
  end

  // Overlapping regions: any execute-never hit blocks the fetch
  wire fetchBlockedNow = chkFetch && (|xnNow); // RULE4

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      chkResult <= '0;
    else
    begin
      chkResult.hit <= hitNow;
      chkResult.fetchBlocked <= fetchBlockedNow;
    end
  end

endmodule : mra_regs

// >>> verification/mra_regs_sva.sv
`timescale 1ns/1ps
module mra_regs_sva
  import mra_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic [MRA_ADDR_W-1:0] s_axi_araddr, // AR
  input wire logic s_axi_arvalid, // AR
  input wire logic s_axi_arready, // AR
  input wire logic [31:0] s_axi_rdata, // R
  input wire logic s_axi_rvalid, // R
  input wire logic s_axi_rready, // R
  input wire logic s_axi_awvalid, // AW
  input wire logic s_axi_awready, // AW
  input wire logic s_axi_wvalid, // W
  input wire logic s_axi_wready, // W
  input wire logic s_axi_bvalid, // B
  input wire logic chkFetch, // Fetch
  input wire mra_check_t chkResult // Result
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic baseRd;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire isBase = s_axi_araddr inside {MRA_OFF_BASE, MRA_OFF_BASE_A1,
    MRA_OFF_BASE_A2, MRA_OFF_BASE_A3};
  // Cannot change while rvalid, as arready is low then
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      baseRd <= 1'b0;
    else if (arTake)
      baseRd <= isBase;
  property p_wlat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_wlat: assert property (p_wlat)
    else $error("write answer late");
  property p_whold;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready;
  endproperty
  a_whold: assert property (p_whold)
    else $error("write channel not held");
  property p_arready;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_arready: assert property (p_arready)
    else $error("arready not inverse of rvalid");
  property p_rlat;
    arTake |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat)
    else $error("read answer late");
  property p_rdrop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rdrop: assert property (p_rdrop)
    else $error("rvalid stuck");
  property p_valid0;
    s_axi_rvalid && baseRd |-> !s_axi_rdata[MRA_POS_VALID];
  endproperty
  a_valid0: assert property (p_valid0)
    else $error("base read shows valid bit");
  property p_fetch;
    chkResult.fetchBlocked |-> $past(chkFetch);
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("data access blocked as fetch");
  property p_hit;
    chkResult.fetchBlocked |-> chkResult.hit != 8'h00;
  endproperty
  a_hit: assert property (p_hit)
    else $error("fetch blocked without region");
endmodule : mra_regs_sva

// >>> verification/mra_core_model.sv
`timescale 1ns/1ps
module mra_core_model (
  input wire logic mclk, // Core clock
  input wire logic [31:0] reqAddr, // Next access
  input wire logic reqFetch, // Next is a fetch
  output logic [31:0] chkAddr = 32'h0, // Access presented
  output logic chkFetch = 1'b0 // Fetch qualifier
);
  // Launched on the clock edge, like a core bus stage
  always @(posedge mclk)
  begin
    chkAddr <= reqAddr;
    chkFetch <= reqFetch;
  end
endmodule : mra_core_model

// >>> verification/tb_mpu_region_attr_regs.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  errors++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_mpu_region_attr_regs;
  import mra_pkg::*;
  typedef struct packed {
    logic [7:0] wa; logic [31:0] wd; logic [3:0] ws; logic [7:0] ra;
    logic [31:0] rd; logic [31:0] ca; logic cf; logic [8:0] cr;
  } mra_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, reqAddr = 32'h0, chkAddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, reqFetch = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, chkFetch;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] data;
  mra_check_t chkResult;
  int errors = 0, checks_done = 0;
  mra_row_t rows [14] = '{
    '{8'h04, 32'h0, 4'hf, 8'h10, 32'h0, 32'h0, 1'h0, 9'h0},
    '{8'h08, 32'h2, 4'hf, 8'h08, 32'h2, 32'h0, 1'h0, 9'h0},
    '{8'h10, 32'hffffffff, 4'hf, 8'h10, 32'h173fff3f, 32'h0, 1'h1,
      9'h000},
    '{8'h10, 32'h13, 4'h3, 8'h10, 32'h173f0013, 32'h3fc, 1'h1,
      9'h009},
    '{8'h18, 32'h0, 4'hc, 8'h10, 32'h13, 32'h3fc, 1'h1, 9'h008},
    '{8'h08, 32'h3, 4'hf, 8'h10, 32'h0, 32'h400, 1'h0, 9'h0},
    '{8'h0c, 32'h20000015, 4'hf, 8'h08, 32'h5, 32'h3fc, 1'h0,
      9'h008},
    '{8'h14, 32'h40000002, 4'hf, 8'h0c, 32'h40000005, 32'h0, 1'h0,
      9'h008},
    '{8'h10, 32'h413, 4'hf, 8'h18, 32'h413, 32'h40000100, 1'h0,
      9'h0},
    '{8'h04, 32'h0, 4'hf, 8'h0c, 32'h40000005, 32'h40000080, 1'h0,
      9'h040},
    '{8'h10, 32'h412, 4'hf, 8'h04, 32'h0, 32'h40000080, 1'h0, 9'h0},
    '{8'h10, 32'h3f, 4'hf, 8'h0c, 32'h5, 32'h90000000, 1'h0, 9'h040},
    '{8'h00, 32'hffffffff, 4'hf, 8'h00, 32'h800, 32'h0, 1'h0, 9'h048},
    '{8'h08, 32'hf, 4'hf, 8'h08, 32'h7, 32'h0, 1'h1, 9'h048}
  };
  mra_regs DUT (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .chkAddr, .chkFetch, .chkResult);
  mra_core_model u_core (.mclk, .reqAddr, .reqFetch, .chkAddr, .chkFetch);
  always #4 mclk = ~mclk;
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb)
      begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic ta, tv;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      tv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tv)
      begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (rows[i])
    begin
      reqAddr <= rows[i].ca;
      reqFetch <= rows[i].cf;
      wr(rows[i].wa, rows[i].wd, rows[i].ws, resp);
      `CHK("bresp", (rows[i].wa inside {MRA_OFF_TYPE, 8'h04}) ?
        MRA_RESP_SLVERR : MRA_RESP_OKAY, resp)
      rd(rows[i].ra, data, resp);
      `CHK("rresp", (rows[i].ra == 8'h04) ?
        MRA_RESP_SLVERR : MRA_RESP_OKAY, resp)
      `CHK("rdata", rows[i].rd, data)
      @(negedge mclk);
      `CHK("chkResult", rows[i].cr, chkResult)
      @(posedge mclk);
    end
    // Reset in mid-run must wipe region state and selection
    rst <= 1'b1;
    @(negedge mclk);
    `CHK("chkResult", 9'h0, chkResult)
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(MRA_OFF_BASE, data, resp);
    `CHK("base", 32'h0, data)
    end_sim();
  end
  initial
  begin
    #20000;
    errors++;
    end_sim();
  end
endmodule : tb_mpu_region_attr_regs
bind mra_regs mra_regs_sva u_sva (.mclk, .rst, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .chkFetch, .chkResult);
